// ==== core/pfir_cfg_map.svh ====
// Register offsets, field positions and reset values for the FIR configuration block
`ifndef PFIR_CFG_MAP_SVH
`define PFIR_CFG_MAP_SVH
`define PFIR_OFS_INDEX     16'h0008
`define PFIR_OFS_XFER      16'h000F
`define PFIR_OFS_MODE      16'h0DF8
`define PFIR_OFS_GAIN      16'h0DF9
`define PFIR_OFS_XBANK     16'h0E00
`define PFIR_OFS_XBANK_END 16'h0E2F
`define PFIR_OFS_YBANK     16'h0F00
`define PFIR_OFS_YBANK_END 16'h0F2F
`define PFIR_OFS_DELAY     16'h0F30
`define PFIR_IDX_I         8'h01
`define PFIR_IDX_Q         8'h02
`define PFIR_XFER_GO       8'h01
`define PFIR_MODE_MSB      2
`define PFIR_YGAIN_LSB     4
`define PFIR_XGAIN_LSB     0
`define PFIR_GAIN_W        3
`define PFIR_RST_INDEX     8'h03
`define PFIR_RST_BYTE      8'h00
`define PFIR_DELAY_MAX     8'h2F
`endif

// ==== core/pfir_cfg_pkg.sv ====
// Types for the FIR configuration block
package pfir_cfg_pkg;
  typedef enum logic [2:0] {
    PFIR_BYPASS   = 3'h0,
    PFIR_X24      = 3'h1,
    PFIR_XY48     = 3'h2,
    PFIR_CASCADE  = 3'h4,
    PFIR_FULL_CPX = 3'h5,
    PFIR_HALF_CPX = 3'h6,
    PFIR_REAL96   = 3'h7
  } pfir_mode_t;
  typedef logic signed [15:0] pfir_coef_t;
endpackage : pfir_cfg_pkg

// ==== core/pfir_cfg.sv ====
// Programmable FIR configuration, shadow coefficient banks and transfer logic
// Function
// - Index 0x01 selects I, 0x02 Q
// - Per-path mode and gain registers
// - Coefficient writes hit shadow; transfer copies
// - GPIO rising edge triggers transfer
// - Mode field decodes bypass/24/48/cascade
// - Y gain bits 6:4 five codes
// - X gain bits 2:0, bits 7,3 reserved
// - Coefficients are signed Q1.15
// - X bank low byte even address
// - Y bank same byte order
// - Y bank role follows mode
// - 96-tap uses opposite path banks high
// - Tapped delay 0..47, half complex only
// - Full complex cross-couples I and Q
// - Half complex passes I unfiltered
`include "pfir_cfg_map.svh"
`timescale 1ns/10ps
`default_nettype none
module pfir_cfg
  import pfir_cfg_pkg::*;
#(
  parameter int NTAP = 24
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  input  wire logic [15:0]  reg_addr_i,
  input  wire logic [7:0]   reg_wdata_i,
  output logic      [7:0]   reg_rdata_o,
  input  wire logic         gpio_xfer_en_i,
  input  wire logic         gpio_xfer_i,
  output logic      [2:0]   mode_i_o,
  output logic      [2:0]   mode_q_o,
  output logic      [2:0]   xgain_i_o,
  output logic      [2:0]   ygain_i_o,
  output logic      [2:0]   xgain_q_o,
  output logic      [2:0]   ygain_q_o,
  output logic      [5:0]   delay_i_o,
  output logic      [5:0]   delay_q_o,
  output logic              xfer_pulse_o,
  output logic      [15:0]  act_inphase_first_bank_o       [NTAP],
  output logic      [15:0]  act_inphase_second_bank_o      [NTAP],
  output logic      [15:0]  act_quadrature_first_bank_o    [NTAP],
  output logic      [15:0]  act_quadrature_second_bank_o   [NTAP],
  output logic              cfg_err_o
);
  // Taps are reached through a 48-byte address window per bank, so other bank depths cannot be served
  if (NTAP != 24) begin : g_bad_ntap
    $error("pfir_cfg: bank depth must be 24");
  end

  localparam int BANK_BYTES = 2 * NTAP;

  logic [7:0] index_q;
  logic [7:0] mode_q    [2];
  logic [7:0] gain_q    [2];
  logic [7:0] delay_q   [2];
  logic [7:0] sh_x_q    [2][BANK_BYTES];
  logic [7:0] sh_y_q    [2][BANK_BYTES];
  logic       gpio_q;
  logic       gpio_rise;
  logic       xfer_wr;
  logic       xfer_d;
  logic       wr_sel;
  logic       path;
  logic       sel_ok;
  logic       hit_index;
  logic       hit_xfer;
  logic       hit_mode;
  logic       hit_gain;
  logic       hit_delay;
  logic       hit_xbank;
  logic       hit_ybank;

  // Bank byte offset from an address; low byte sits at the even address
  function automatic logic [5:0] pfir_byte_idx(input logic [15:0] a);
    return a[5:0];
  endfunction : pfir_byte_idx

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  // Two shadow bytes make one Q1.15 tap, low byte first
  function automatic pfir_coef_t pfir_word(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo};
  endfunction : pfir_word

  // Address decode, shared by the write and read paths
  assign hit_index = (reg_addr_i == `PFIR_OFS_INDEX);
  assign hit_xfer  = (reg_addr_i == `PFIR_OFS_XFER);
  assign hit_mode  = (reg_addr_i == `PFIR_OFS_MODE);
  assign hit_gain  = (reg_addr_i == `PFIR_OFS_GAIN);
  assign hit_delay = (reg_addr_i == `PFIR_OFS_DELAY);
  assign hit_xbank = in_range(reg_addr_i, `PFIR_OFS_XBANK, `PFIR_OFS_XBANK_END);
  assign hit_ybank = in_range(reg_addr_i, `PFIR_OFS_YBANK, `PFIR_OFS_YBANK_END);

  // Filter registers answer only for a valid path selection
  assign sel_ok = (index_q == `PFIR_IDX_I) || (index_q == `PFIR_IDX_Q);
  assign path   = (index_q == `PFIR_IDX_Q);
  assign wr_sel = reg_wr_i && sel_ok;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      index_q <= `PFIR_RST_INDEX;
    end else if (reg_wr_i && hit_index) begin
      index_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q[0] <= `PFIR_RST_BYTE;
      mode_q[1] <= `PFIR_RST_BYTE;
    end else if (wr_sel && hit_mode) begin
      // Reserved bits are dropped on write so they read back as zero
      mode_q[path] <= {5'h00, reg_wdata_i[`PFIR_MODE_MSB:0]};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gain_q[0] <= `PFIR_RST_BYTE;
      gain_q[1] <= `PFIR_RST_BYTE;
    end else if (wr_sel && hit_gain) begin
      // Bits 7 and 3 are reserved and always read as zero
      gain_q[path] <= {1'b0, reg_wdata_i[6:4], 1'b0, reg_wdata_i[2:0]};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      delay_q[0] <= `PFIR_RST_BYTE;
      delay_q[1] <= `PFIR_RST_BYTE;
    end else if (wr_sel && hit_delay) begin
      // Out-of-range delays clamp to the last tap rather than wrap
      delay_q[path] <= (reg_wdata_i > `PFIR_DELAY_MAX) ? `PFIR_DELAY_MAX
                                                       : reg_wdata_i;
    end
  end

  // Shadow banks; the filter never sees these until a transfer
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < 2; p++) begin
        for (int b = 0; b < BANK_BYTES; b++) begin
          sh_x_q[p][b] <= `PFIR_RST_BYTE;
          sh_y_q[p][b] <= `PFIR_RST_BYTE;
        end
      end
    end else if (wr_sel) begin
      if (hit_xbank) begin
        sh_x_q[path][pfir_byte_idx(reg_addr_i)] <= reg_wdata_i;
      end
      if (hit_ybank) begin
        sh_y_q[path][pfir_byte_idx(reg_addr_i)] <= reg_wdata_i;
      end
    end
  end

  // Previous pin level; resets to the idle low so reset makes no false edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gpio_q <= 1'b0;
    end else begin
      gpio_q <= gpio_xfer_i;
    end
  end

  // Transfer request: write of 0x01 to the transfer register or rising edge of the GPIO trigger
  assign gpio_rise = gpio_xfer_en_i && gpio_xfer_i && !gpio_q;
  assign xfer_wr   = reg_wr_i && hit_xfer && (reg_wdata_i == `PFIR_XFER_GO);
  assign xfer_d    = xfer_wr || gpio_rise;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xfer_pulse_o <= 1'b0;
    end else begin
      xfer_pulse_o <= xfer_d;
    end
  end

  // Mode and gain are live: the filter follows them without a transfer
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_i_o  <= 3'h0;
      mode_q_o  <= 3'h0;
      xgain_i_o <= 3'h0;
      ygain_i_o <= 3'h0;
      xgain_q_o <= 3'h0;
      ygain_q_o <= 3'h0;
    end else begin
      mode_i_o  <= mode_q[0][2:0];
      mode_q_o  <= mode_q[1][2:0];
      xgain_i_o <= gain_q[0][`PFIR_XGAIN_LSB +: `PFIR_GAIN_W];
      ygain_i_o <= gain_q[0][`PFIR_YGAIN_LSB +: `PFIR_GAIN_W];
      xgain_q_o <= gain_q[1][`PFIR_XGAIN_LSB +: `PFIR_GAIN_W];
      ygain_q_o <= gain_q[1][`PFIR_YGAIN_LSB +: `PFIR_GAIN_W];
    end
  end

  // Delay taps move with the coefficients, not on the register write
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      delay_i_o <= 6'h00;
      delay_q_o <= 6'h00;
    end else if (xfer_d) begin
      delay_i_o <= delay_q[0][5:0];
      delay_q_o <= delay_q[1][5:0];
    end
  end

  // All four banks copy on the same edge, so taps never mix old and new values.
  // Per-mode tap routing is left to the datapath, which reads banks and modes.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int t = 0; t < NTAP; t++) begin
        act_inphase_first_bank_o[t] <= 16'h0000;
      end
    end else if (xfer_d) begin
      for (int t = 0; t < NTAP; t++) begin
        act_inphase_first_bank_o[t] <= pfir_word(sh_x_q[0][2*t],
                                                 sh_x_q[0][2*t+1]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int t = 0; t < NTAP; t++) begin
        act_inphase_second_bank_o[t] <= 16'h0000;
      end
    end else if (xfer_d) begin
      for (int t = 0; t < NTAP; t++) begin
        act_inphase_second_bank_o[t] <= pfir_word(sh_y_q[0][2*t],
                                                  sh_y_q[0][2*t+1]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int t = 0; t < NTAP; t++) begin
        act_quadrature_first_bank_o[t] <= 16'h0000;
      end
    end else if (xfer_d) begin
      for (int t = 0; t < NTAP; t++) begin
        act_quadrature_first_bank_o[t] <= pfir_word(sh_x_q[1][2*t],
                                                    sh_x_q[1][2*t+1]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int t = 0; t < NTAP; t++) begin
        act_quadrature_second_bank_o[t] <= 16'h0000;
      end
    end else if (xfer_d) begin
      for (int t = 0; t < NTAP; t++) begin
        act_quadrature_second_bank_o[t] <= pfir_word(sh_y_q[1][2*t],
                                                     sh_y_q[1][2*t+1]);
      end
    end
  end

  // Flags a mode pair the filter cannot build; the host must avoid these
  function automatic logic pair_bad(input logic [2:0] a, input logic [2:0] b);
    return (a == PFIR_FULL_CPX && b != PFIR_FULL_CPX)
        || (a == PFIR_HALF_CPX && b != PFIR_XY48)
        || (a == PFIR_REAL96   && b != PFIR_BYPASS)
        || (a == 3'h3);
  endfunction : pair_bad

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= pair_bad(mode_q[0][2:0], mode_q[1][2:0])
                || pair_bad(mode_q[1][2:0], mode_q[0][2:0]);
    end
  end

  // Read data registered: one cycle after reg_rd_i, held until the next read
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 8'h00;
      if (hit_index) begin
        reg_rdata_o <= index_q;
      end else if (sel_ok) begin
        if (hit_mode) begin
          reg_rdata_o <= mode_q[path];
        end else if (hit_gain) begin
          reg_rdata_o <= gain_q[path];
        end else if (hit_delay) begin
          reg_rdata_o <= delay_q[path];
        end else if (hit_xbank) begin
          reg_rdata_o <= sh_x_q[path][pfir_byte_idx(reg_addr_i)];
        end else if (hit_ybank) begin
          reg_rdata_o <= sh_y_q[path][pfir_byte_idx(reg_addr_i)];
        end
      end
    end
  end
endmodule : pfir_cfg
`default_nettype wire

// ==== testbench/pfir_cfg_sva.sv ====
// Checker for the FIR configuration block
`timescale 1ns/10ps
`default_nettype none
module pfir_cfg_sva (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        gpio_xfer_en_i,
  input wire logic        gpio_xfer_i,
  input wire logic [2:0]  mode_i_o,
  input wire logic [2:0]  mode_q_o,
  input wire logic [5:0]  delay_i_o,
  input wire logic        xfer_pulse_o,
  input wire logic        cfg_err_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  logic [7:0] idx_q;
  logic       go, mw, gr;
  assign go = reg_wr_i && reg_addr_i == 16'h000F && reg_wdata_i == 8'h01;
  assign mw = reg_wr_i && reg_addr_i == 16'h0DF8;
  assign gr = gpio_xfer_en_i && gpio_xfer_i;
  // Own index copy, so mode checks do not trust the design
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i) idx_q <= 8'h03;
    else if (reg_wr_i && reg_addr_i == 16'h0008) idx_q <= reg_wdata_i;
  property p_xfer; go |=> xfer_pulse_o; endproperty
  a_xfer: assert property (p_xfer) else $error("no pulse");
  property p_gpio; gr && !$past(gpio_xfer_i) |=> xfer_pulse_o; endproperty
  a_gpio: assert property (p_gpio) else $error("no pin pulse");
  property p_cause; xfer_pulse_o |-> $past(go) || $past(gr) && !$past(gpio_xfer_i, 2); endproperty
  a_cause: assert property (p_cause) else $error("stray pulse");
  property p_hold; !xfer_pulse_o |-> $stable(delay_i_o); endproperty
  a_hold: assert property (p_hold) else $error("delay moved");
  property p_mi; mw && idx_q == 8'h01 |-> ##2 mode_i_o == $past(reg_wdata_i[2:0], 2); endproperty
  a_mi: assert property (p_mi) else $error("i mode");
  property p_mq; mw && idx_q == 8'h02 |-> ##2 mode_q_o == $past(reg_wdata_i[2:0], 2); endproperty
  a_mq: assert property (p_mq) else $error("q mode");
  property p_mx; mw && idx_q != 8'h01 && idx_q != 8'h02 |-> ##2 $stable({mode_i_o, mode_q_o});
  endproperty
  a_mx: assert property (p_mx) else $error("no path");
  property p_err; (mode_i_o == 3'h7 && mode_q_o != 3'h0) [*2] |-> cfg_err_o; endproperty
  a_err: assert property (p_err) else $error("pair");
  c_xfer: cover property (go ##1 xfer_pulse_o);
  c_gpio: cover property (gr && !$past(gpio_xfer_i));
  c_err: cover property (cfg_err_o);
endmodule : pfir_cfg_sva
bind pfir_cfg pfir_cfg_sva u_sva (
  .clk_sys_i      (clk_sys_i),
  .rstn_i         (rstn_i),
  .reg_wr_i       (reg_wr_i),
  .reg_addr_i     (reg_addr_i),
  .reg_wdata_i    (reg_wdata_i),
  .gpio_xfer_en_i (gpio_xfer_en_i),
  .gpio_xfer_i    (gpio_xfer_i),
  .mode_i_o       (mode_i_o),
  .mode_q_o       (mode_q_o),
  .delay_i_o      (delay_i_o),
  .xfer_pulse_o   (xfer_pulse_o),
  .cfg_err_o      (cfg_err_o)
);
`default_nettype wire

// ==== testbench/pfir_host.sv ====
// Host model on the byte register bus
`timescale 1ns/10ps
`default_nettype none
module pfir_host (
  input  wire logic        clk_sys_i,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [15:0] addr_o,
  output var  logic [7:0]  wdata_o,
  input  wire logic [7:0]  rdata_i
);
  initial {wr_o, rd_o, addr_o, wdata_o} = 26'h0;
  // Idle cycle after each access; released lines show the inverse, never stale data
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_sys_i);
    {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
    @(negedge clk_sys_i);
    {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    q = rdata_i;
  endtask : acc
endmodule : pfir_host
`default_nettype wire

// ==== testbench/test_programmable_fir_config.sv ====
// Self-checking bench for the FIR configuration block
`timescale 1ns/10ps
`default_nettype none
module test_programmable_fir_config;
  logic        clk_sys_i, rstn_i, wr, rd, gen, gpio, pul, err;
  logic [15:0] ad, b0 [24], b1 [24], b2 [24], b3 [24], sh [4][24], ex [4][24];
  logic [7:0]  wd, rdat, r, d;
  logic [2:0]  mi, mq, xig, yig, xqg, yqg, gc [5] = '{3'h6, 3'h7, 3'h0, 3'h1, 3'h2};
  logic [5:0]  di, dq, sq [10] = '{6'h09, 6'h0A, 6'h0C, 6'h08, 6'h17, 6'h36, 6'h0A, 6'h2F,
                                   6'h35, 6'h0D};
  int          err_count = 0, n_compared = 0, cyc = 0;
  pfir_cfg dut (.clk_sys_i, .rstn_i, .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .gpio_xfer_en_i(gen), .gpio_xfer_i(gpio),
    .mode_i_o(mi), .mode_q_o(mq), .xgain_i_o(xig), .ygain_i_o(yig), .xgain_q_o(xqg),
    .ygain_q_o(yqg), .delay_i_o(di), .delay_q_o(dq), .xfer_pulse_o(pul),
    .act_inphase_first_bank_o(b0), .act_inphase_second_bank_o(b1),
    .act_quadrature_first_bank_o(b2), .act_quadrature_second_bank_o(b3), .cfg_err_o(err));
  pfir_host h (.clk_sys_i, .wr_o(wr), .rd_o(rd), .addr_o(ad), .wdata_o(wd), .rdata_i(rdat));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic banks();
    @(negedge clk_sys_i);
    for (int n = 0; n < 24; n++) begin
      cmp(b0[n] ^ ex[0][n] | b1[n] ^ ex[1][n] | b2[n] ^ ex[2][n] | b3[n] ^ ex[3][n], 16'h0);
    end
  endtask : banks
  task automatic load(input logic p);
    logic [15:0] v;
    h.acc(1, 16'h0008, {6'h00, p, !p}, r);
    for (int n = 0; n < 48; n++) begin
      v = 16'($urandom);
      sh[2 * p + n / 24][n % 24] = v;
      h.acc(1, 16'h0E00 + 16'(n / 24 * 256 + n % 24 * 2), v[7:0], r);
      h.acc(1, 16'h0E01 + 16'(n / 24 * 256 + n % 24 * 2), v[15:8], r);
    end
  endtask : load
  task automatic mset(input logic [5:0] s);
    h.acc(1, 16'h0008, {6'h00, s[4:3]}, r);
    h.acc(1, 16'h0DF8, {5'($urandom), s[2:0]}, r);
    h.acc(0, 16'h0DF8, 8'h00, r);
    cmp(r, s[2:0]);
    cmp(s[4] ? mq : mi, s[2:0]);
    cmp(err, s[5]);
  endtask : mset
  task automatic trig(input logic e);
    @(negedge clk_sys_i);
    {gen, gpio} = {e, 1'b1};
    @(negedge clk_sys_i);
    gpio = 1'b0;
  endtask : trig
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    {rstn_i, gen, gpio} = 3'b000;
    ex = '{default: '0};
    void'($urandom(67));
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rstn_i = 1'b1;
    h.acc(0, 16'h0008, 8'h00, r);
    cmp(r, 8'h03);
    h.acc(1, 16'h0DF8, 8'h01, r);
    cmp(mi, 3'h0);
    foreach (sq[k]) mset(sq[k]);
    mset(6'h2B);
    mset(6'h0D);
    for (int k = 0; k < 5; k++) begin
      d = {1'($urandom), gc[k], 1'($urandom), gc[4 - k]};
      h.acc(1, 16'h0DF9, d, r);
      h.acc(0, 16'h0DF9, 8'h00, r);
      cmp(r, d & 8'h77);
      cmp({yig, xig, xqg, yqg}, {gc[k], gc[4 - k], 6'h00});
    end
    repeat (500) @(posedge clk_sys_i);
    load(0);
    load(1);
    h.acc(1, 16'h0F30, 8'h3C, r);
    h.acc(1, 16'h000F, 8'h02, r);
    banks();
    h.acc(1, 16'h000F, 8'h01, r);
    ex = sh;
    banks();
    cmp(dq, 6'h2F);
    cmp(di, 6'h00);
    h.acc(0, 16'h0F30, 8'h00, r);
    cmp(r, 8'h2F);
    load(0);
    trig(0);
    banks();
    trig(1);
    ex = sh;
    banks();
    h.acc(0, 16'h0100, 8'h00, r);
    cmp(r, 8'h00);
    end_of_test();
  end
endmodule : test_programmable_fir_config
`default_nettype wire
